// ---- src/dram_address_strobe_driver.sv ----
// Address multiplexer, strobe driver and refresh counter for four DRAM banks
// How it works
// - Address outputs come from row latch, column latch or refresh counter.
// - Refresh select high strobes decoded bank; low strobes all four banks.
// - Auto-refresh mode uses row/column pin as refresh clock, else selects latch.
// - Column strobe input gates column strobe in modes 3,4, extends it in mode 6; else unused.
// - Latches pass through while latch strobe high, hold after it falls.
// - Device select high floats addresses, drives controls high then weak high.
// - Outputs drive again about 50 ns after device select returns low.
// - Count flag pin pulled low externally clears the refresh counter.
// - Flag low at end-of-count in modes 0,2; refresh request in mode 1.
// - Write strobe output is a buffered copy of write request input.
// - Modes 5,6 drop column strobe once column address is presented.
// - Modes 3b,4 drop column strobe once both row/column and column strobe input are low.
// - Column strobe stays high during every refresh cycle.
// - Bank select latched with addresses; decoded for row strobes; sets end-of-count.
// - Refresh counter always counts to 511 then wraps to zero.
// - Access starts with strobes high; latched row address then appears.
// - Reset clears counter and control state, end-of-count to 127.
// - During initialization controls held high and addresses floating.
// - Modes 0 and 4 take strobe timing directly from system inputs.
// - Mode 1 raises forced refresh request when no hidden refresh occurred.
`timescale 1ns/10ps
module dram_address_strobe_driver
	import dram_strobe_pkg::*;
(
	input  wire logic                ref_clk_i,
	input  wire logic                reset_n_i,
	input  wire logic [ADDR_W-1:0]   row_addr_in_i,
	input  wire logic [ADDR_W-1:0]   col_addr_in_i,
	input  wire logic [1:0]          bank_select_i,
	input  wire logic                address_latch_strobe_i,
	input  wire logic                device_select_n_i,
	input  wire logic                row_strobe_in_n_i,
	input  wire logic                row_column_select_i,
	input  wire logic                column_strobe_in_n_i,
	input  wire logic [MODE_W-1:0]   mode_select_bits_i,
	input  wire logic                write_request_in_n_i,
	input  wire logic                count_flag_io_i,
	output logic                     count_flag_io_o,
	output logic                     count_flag_io_oe_o,
	output logic [ADDR_W-1:0]        muxed_addr_out_o,
	output logic                     muxed_addr_out_oe_o,
	output logic [BANKS-1:0]         row_strobe_out_n_o,
	output logic                     column_strobe_out_n_o,
	output logic                     write_strobe_out_n_o,
	output logic                     control_out_oe_o
);
	localparam int SYNC_W = 2 * ADDR_W + 2 + 1 + 1 + 1 + 1 + 1 + MODE_W + 1 + 1;
	// Idle pin levels, so no false edge follows reset
	localparam logic [SYNC_W-1:0] SYNC_IDLE = {{(2 * ADDR_W + 2){1'b0}}, 2'h0, 3'h7,
		MODE_EXT_ACCESS, 2'h3};

	typedef struct packed {
		logic [SYNC_W-1:0] sync1;
		logic [SYNC_W-1:0] sync2;
		logic              prev_refresh_select;
		logic              prev_row_strobe_in;
		logic              prev_rc;
		logic [ADDR_W-1:0] row_latch;
		logic [ADDR_W-1:0] col_latch;
		logic [1:0]        bank_latch;
		logic [ADDR_W-1:0] count;
		logic [1:0]        eoc_sel;
		logic              hidden_done;
		logic              refresh_req;
		out_state_type     out_state;
		logic [3:0]        timer;
		logic [1:0]        init_timer;
		logic [ADDR_W-1:0] addr_out;
		logic              addr_oe;
		logic [BANKS-1:0]  ras_n;
		logic              cas_n;
		logic              we_n;
		logic              ctrl_oe;
		logic              flag_oe;
		logic [1:0]        flag_hist;
		logic [3:0]        reen_wait;
	} state_type;

	state_type cur;
	state_type next_cur;

	logic [SYNC_W-1:0] pins;
	assign pins = {row_addr_in_i, col_addr_in_i, bank_select_i, address_latch_strobe_i,
		device_select_n_i, row_strobe_in_n_i, row_column_select_i, column_strobe_in_n_i,
		mode_select_bits_i, write_request_in_n_i, count_flag_io_i};

	logic [ADDR_W-1:0] s_row;
	logic [ADDR_W-1:0] s_col;
	logic [1:0]        s_bank;
	logic              s_ads;
	logic              s_cs_n;
	logic              s_row_strobe_in_n;
	logic              s_rc;
	logic              s_column_strobe_in_n;
	logic [2:0]        s_mode;
	logic              s_win_n;
	logic              s_flag;
	assign {s_row, s_col, s_bank, s_ads, s_cs_n, s_row_strobe_in_n, s_rc, s_column_strobe_in_n, s_mode, s_win_n,
		s_flag} = cur.sync2;

	logic              refresh_select;
	logic              refresh_mode;
	logic              refreshing;
	logic [ADDR_W-1:0] eoc_value;
	logic              at_eoc;
	addr_src_type      src;
	logic [BANKS-1:0]  bank_dec;
	logic              cas_low;

	always_comb begin
		next_cur = cur;
		// Two-flop synchroniser on every pin input
		next_cur.sync1 = pins;
		next_cur.sync2 = cur.sync1;
		next_cur.prev_refresh_select = s_mode[2];
		next_cur.prev_row_strobe_in = s_row_strobe_in_n;
		next_cur.prev_rc = s_rc;
		next_cur.flag_hist = {cur.flag_hist[0], cur.flag_oe};
		next_cur.reen_wait = (cur.out_state == OUT_REENABLE) ? cur.reen_wait + 4'h1 : 4'h0;
		refresh_select = s_mode[2];
		refresh_mode = (s_mode == MODE_EXT_REFRESH) || (s_mode == MODE_AUTO_REFRESH)
			|| (s_mode == MODE_BURST_REFRESH);
		refreshing = !refresh_select && !s_row_strobe_in_n;

		// Fall-through latches; hold once strobe is low
		if (s_ads) begin
			next_cur.row_latch = s_row;
			next_cur.col_latch = s_col;
			next_cur.bank_latch = s_bank;
		end

		// Setup mode loads end-of-count from bank inputs
		if (s_mode == MODE_SET_EOC) begin
			next_cur.eoc_sel = s_bank;
		end
		unique case (cur.eoc_sel)
			EOC_SEL_127: eoc_value = EOC_127;
			EOC_SEL_255: eoc_value = EOC_255;
			default: eoc_value = EOC_511;
		endcase
		at_eoc = (cur.count == eoc_value);

		// Counter counts freely to 511 then wraps
		if ((s_row_strobe_in_n && !cur.prev_row_strobe_in && !refresh_select) || (refresh_select && !cur.prev_refresh_select && !s_row_strobe_in_n)) begin
			next_cur.count = cur.count + 9'h001;
		end
		// External low on flag pin clears counter
		// Own flag echoes back through the synchroniser; mask it
		if (!s_flag && !cur.flag_oe && cur.flag_hist == 2'h0) begin
			next_cur.count = COUNT_RESET;
		end

		// Hidden refresh tracking against refresh clock
		if (s_mode == MODE_AUTO_ACCESS && s_rc && s_cs_n && !s_row_strobe_in_n) begin
			next_cur.hidden_done = 1'b1;
		end
		if (s_mode == MODE_AUTO_REFRESH && refreshing) begin
			next_cur.hidden_done = 1'b1;
			next_cur.refresh_req = 1'b0;
		end
		if (!s_rc && cur.prev_rc) begin
			next_cur.refresh_req = !cur.hidden_done;
			next_cur.hidden_done = 1'b0;
		end

		// Address source selection
		if (refresh_mode && !refresh_select) begin
			src = SRC_COUNT;
		end else if (s_mode != MODE_AUTO_REFRESH && !s_rc) begin
			src = SRC_COL;
		end else begin
			src = SRC_ROW;
		end
		unique case (src)
			SRC_ROW: next_cur.addr_out = cur.row_latch;
			SRC_COL: next_cur.addr_out = cur.col_latch;
			default: next_cur.addr_out = cur.count;
		endcase

		// Row strobes: decoded bank or all banks
		bank_dec = 4'h1 << cur.bank_latch;
		if (s_row_strobe_in_n) begin
			next_cur.ras_n = 4'hF;
		end else if (refresh_select) begin
			next_cur.ras_n = ~bank_dec;
		end else begin
			next_cur.ras_n = 4'h0;
		end

		// Column strobe generation
		cas_low = 1'b0;
		unique case (s_mode)
			MODE_AUTO_ACCESS: cas_low = !s_row_strobe_in_n && (src == SRC_COL);
			MODE_AUTO_ACCESS_SLOW: cas_low = (!s_row_strobe_in_n && (src == SRC_COL))
				|| (!s_column_strobe_in_n && !cur.cas_n);
			MODE_EXT_ACCESS: cas_low = !s_rc && !s_column_strobe_in_n;
			MODE_ALL_BANK: cas_low = !s_rc && !s_column_strobe_in_n;
			default: cas_low = 1'b0;
		endcase
		next_cur.cas_n = !cas_low;

		// Write strobe follows write request
		next_cur.we_n = s_win_n;

		// Flag pin drive
		if ((s_mode == MODE_EXT_REFRESH && refreshing && at_eoc)
			|| (s_mode == MODE_BURST_REFRESH && at_eoc)
			|| (s_mode == MODE_AUTO_REFRESH && cur.refresh_req)) begin
			next_cur.flag_oe = 1'b1;
		end else begin
			next_cur.flag_oe = 1'b0;
		end

		// Output enable sequencing on device select
		unique case (cur.out_state)
			OUT_INIT: begin
				next_cur.addr_oe = 1'b0;
				next_cur.ctrl_oe = 1'b1;
				next_cur.ras_n = 4'hF;
				next_cur.cas_n = 1'b1;
				next_cur.we_n = 1'b1;
				next_cur.init_timer = cur.init_timer + 2'h1;
				if (cur.init_timer == INIT_CNT) begin
					next_cur.out_state = OUT_ACTIVE;
				end
			end
			OUT_ACTIVE: begin
				next_cur.addr_oe = 1'b1;
				next_cur.ctrl_oe = 1'b1;
				if (s_cs_n && !refreshing) begin
					next_cur.out_state = OUT_PULLUP;
					next_cur.timer = 4'h0;
					next_cur.addr_oe = 1'b0;
				end
			end
			OUT_PULLUP: begin
				next_cur.addr_oe = 1'b0;
				next_cur.ctrl_oe = 1'b1;
				next_cur.ras_n = 4'hF;
				next_cur.cas_n = 1'b1;
				next_cur.we_n = 1'b1;
				next_cur.timer = cur.timer + 4'h1;
				if (cur.timer + 4'h1 >= PRECHARGE_CNT) begin
					next_cur.out_state = OUT_FLOAT;
				end
			end
			OUT_FLOAT: begin
				next_cur.addr_oe = 1'b0;
				next_cur.ctrl_oe = 1'b0;
				next_cur.ras_n = 4'hF;
				next_cur.cas_n = 1'b1;
				next_cur.we_n = 1'b1;
				if (!s_cs_n || refreshing) begin
					next_cur.out_state = refreshing ? OUT_ACTIVE : OUT_REENABLE;
					next_cur.timer = 4'h0;
				end
			end
			OUT_REENABLE: begin
				next_cur.addr_oe = 1'b0;
				next_cur.ctrl_oe = 1'b0;
				next_cur.ras_n = 4'hF;
				next_cur.cas_n = 1'b1;
				next_cur.we_n = 1'b1;
				next_cur.timer = cur.timer + 4'h1;
				if (s_cs_n) begin
					next_cur.out_state = OUT_FLOAT;
				end else if (cur.timer + 4'h1 >= REENABLE_CNT) begin
					next_cur.out_state = OUT_ACTIVE;
				end
			end
		endcase
	end

	// Reset clears counter and control state, end-of-count 127
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cur <= '0;
			cur.sync1 <= SYNC_IDLE;
			cur.sync2 <= SYNC_IDLE;
			cur.eoc_sel <= EOC_RESET;
			cur.count <= COUNT_RESET;
			cur.out_state <= OUT_INIT;
			cur.ras_n <= 4'hF;
			cur.cas_n <= 1'b1;
			cur.we_n <= 1'b1;
			cur.ctrl_oe <= 1'b1;
			cur.prev_row_strobe_in <= 1'b1;
			cur.prev_refresh_select <= 1'b1;
			cur.prev_rc <= 1'b1;
		end else begin
			cur <= next_cur;
		end
	end

	assign muxed_addr_out_o = cur.addr_out;
	assign muxed_addr_out_oe_o = cur.addr_oe;
	assign row_strobe_out_n_o = cur.ras_n;
	assign column_strobe_out_n_o = cur.cas_n;
	assign write_strobe_out_n_o = cur.we_n;
	assign control_out_oe_o = cur.ctrl_oe;
	assign count_flag_io_o = 1'b0;
	assign count_flag_io_oe_o = cur.flag_oe;

	counter_wrap_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(cur.count == EOC_511 && next_cur.count != EOC_511 && s_flag) |=> cur.count == 9'h000)
		else $error("Refresh counter did not wrap to zero");
	cas_refresh_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		refresh_mode |=> cur.cas_n)
		else $error("Column strobe low during refresh");
	we_follow_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(cur.out_state == OUT_ACTIVE && $stable(cur.out_state)) |=> cur.we_n == $past(s_win_n))
		else $error("Write strobe not following request");
	ras_all_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(cur.out_state == OUT_ACTIVE && !refresh_select && !s_row_strobe_in_n) |=> cur.ras_n == 4'h0)
		else $error("All row strobes not asserted in refresh");
	ras_one_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(cur.out_state == OUT_ACTIVE && refresh_select && !s_row_strobe_in_n) |=> $countones(~cur.ras_n) == 1)
		else $error("More than one bank strobed");
	flag_clear_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(!s_flag && !cur.flag_oe && cur.flag_hist == 2'h0) |=> cur.count == 9'h000)
		else $error("External flag low did not clear counter");
	float_addr_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(cur.out_state == OUT_FLOAT) |=> !cur.addr_oe && !cur.ctrl_oe && cur.cas_n)
		else $error("Outputs driven while deselected");
	reenable_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(cur.out_state == OUT_ACTIVE && $past(cur.out_state) == OUT_REENABLE) |-> cur.reen_wait >= REENABLE_CNT)
		else $error("Outputs re-enabled too early");
	latch_hold_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		!s_ads |=> $stable(cur.row_latch) && $stable(cur.col_latch))
		else $error("Latch changed while strobe low");
	init_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(cur.out_state == OUT_INIT) |-> !cur.addr_oe && cur.ras_n == 4'hF)
		else $error("Outputs active during initialization");

	refresh_c: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		s_mode == MODE_EXT_REFRESH && refreshing && at_eoc);
	access_c: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		s_mode == MODE_EXT_ACCESS && !cur.cas_n);
	deselect_c: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		cur.out_state == OUT_REENABLE ##1 cur.out_state == OUT_ACTIVE);
	request_c: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		cur.refresh_req && s_mode == MODE_AUTO_REFRESH);
endmodule // dram_address_strobe_driver

// ---- src/dram_strobe_pkg.sv ----
// Constants and types for the DRAM address and strobe driver
package dram_strobe_pkg;
	localparam int ADDR_W = 9;
	localparam int BANKS = 4;
	localparam int MODE_W = 3;
	localparam logic [2:0] MODE_EXT_REFRESH = 3'h0;
	localparam logic [2:0] MODE_AUTO_REFRESH = 3'h1;
	localparam logic [2:0] MODE_BURST_REFRESH = 3'h2;
	localparam logic [2:0] MODE_ALL_BANK = 3'h3;
	localparam logic [2:0] MODE_EXT_ACCESS = 3'h4;
	localparam logic [2:0] MODE_AUTO_ACCESS = 3'h5;
	localparam logic [2:0] MODE_AUTO_ACCESS_SLOW = 3'h6;
	localparam logic [2:0] MODE_SET_EOC = 3'h7;
	localparam logic [1:0] EOC_SEL_127 = 2'h0;
	localparam logic [1:0] EOC_SEL_255 = 2'h1;
	localparam logic [1:0] EOC_SEL_511 = 2'h2;
	localparam logic [1:0] EOC_RESET = EOC_SEL_127;
	localparam logic [8:0] EOC_127 = 9'h07F;
	localparam logic [8:0] EOC_255 = 9'h0FF;
	localparam logic [8:0] EOC_511 = 9'h1FF;
	localparam logic [8:0] COUNT_RESET = 9'h000;
	localparam int CLK_PERIOD_PS = 5000;
	localparam int REENABLE_NS = 50;
	localparam int REENABLE_CYC = (REENABLE_NS * 1000) / CLK_PERIOD_PS;
	localparam logic [3:0] REENABLE_CNT = 4'(REENABLE_CYC);
	localparam int PRECHARGE_NS = 5;
	localparam int PRECHARGE_CYC = (PRECHARGE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [3:0] PRECHARGE_CNT = 4'(PRECHARGE_CYC);
	localparam logic [1:0] INIT_CNT = 2'h3;
	typedef enum logic [1:0] {
		SRC_ROW,
		SRC_COL,
		SRC_COUNT
	} addr_src_type;
	typedef enum {
		OUT_INIT,
		OUT_ACTIVE,
		OUT_PULLUP,
		OUT_FLOAT,
		OUT_REENABLE
	} out_state_type;
endpackage

// ---- verification/dram_bank_model.sv ----
// Far-side model: strobe pull-ups, open-collector flag line, released address bus
`timescale 1ns/10ps
module dram_bank_model (
	input  wire logic       ref_clk_i,
	input  wire logic [8:0] addr_i,
	input  wire logic       addr_oe_i,
	input  wire logic [3:0] ras_n_i,
	input  wire logic       ctrl_oe_i,
	input  wire logic       flag_i,
	input  wire logic       flag_oe_i,
	input  wire logic       clear_n_i,
	output logic      [8:0] addr_pin_o,
	output logic      [3:0] ras_pin_o,
	output logic            flag_pin_o
);
	logic [8:0] drift = 9'h155;
	// Released bus alternates: inverted last address, then the last address itself
	always @(posedge ref_clk_i) drift <= addr_oe_i ? ~addr_i : ~drift;
	assign addr_pin_o = addr_oe_i ? addr_i : drift;
	// Weak pull-up keeps released strobes high
	assign ras_pin_o = ctrl_oe_i ? ras_n_i : 4'hF;
	// Pulled up; low if either side sinks it
	assign flag_pin_o = ((flag_oe_i && !flag_i) || !clear_n_i) ? 1'b0 : 1'b1;
endmodule // dram_bank_model

// ---- verification/dram_address_strobe_driver_tb.sv ----
// Self-checking bench for the DRAM address and strobe driver
`timescale 1ns/10ps
module dram_address_strobe_driver_tb;
	import dram_strobe_pkg::*;
	typedef struct {int kind; logic [8:0] exp;} note_type;
	logic        ref_clk_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic [8:0]  row_addr = 9'h000;
	logic [8:0]  col_addr = 9'h000;
	logic [1:0]  bank_select = 2'h0;
	logic        latch = 1'b1;
	logic        select_n = 1'b0;
	logic        ras_in_n = 1'b1;
	logic        row_col = 1'b1;
	logic        cas_in_n = 1'b1;
	logic [2:0]  mode = MODE_EXT_ACCESS;
	logic        win_n = 1'b1;
	logic        clear_n = 1'b1;
	wire         flag_pin, flag_o, flag_oe, addr_oe, cas_o, we_o, ctrl_oe;
	wire  [8:0]  addr_o, addr_pin;
	wire  [3:0]  ras_o, ras_pin;
	note_type    notes[$];
	int          errors = 0;
	int          checks_done = 0;
	logic [31:0] seed = 32'h2113E934;
	logic [8:0]  eocs[3] = '{EOC_127, EOC_255, EOC_511};
	logic [2:0]  amodes[3] = '{MODE_AUTO_ACCESS, MODE_AUTO_ACCESS_SLOW, MODE_ALL_BANK};
	logic [8:0]  gap_ok = 9'h000;

	always #2.5 ref_clk_i = ~ref_clk_i;

	dram_address_strobe_driver dut_u (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
		.row_addr_in_i(row_addr), .col_addr_in_i(col_addr), .bank_select_i(bank_select),
		.address_latch_strobe_i(latch), .device_select_n_i(select_n),
		.row_strobe_in_n_i(ras_in_n), .row_column_select_i(row_col),
		.column_strobe_in_n_i(cas_in_n), .mode_select_bits_i(mode),
		.write_request_in_n_i(win_n), .count_flag_io_i(flag_pin), .count_flag_io_o(flag_o),
		.count_flag_io_oe_o(flag_oe), .muxed_addr_out_o(addr_o), .muxed_addr_out_oe_o(addr_oe),
		.row_strobe_out_n_o(ras_o), .column_strobe_out_n_o(cas_o),
		.write_strobe_out_n_o(we_o), .control_out_oe_o(ctrl_oe));

	dram_bank_model far_u (.ref_clk_i(ref_clk_i), .addr_i(addr_o), .addr_oe_i(addr_oe),
		.ras_n_i(ras_o), .ctrl_oe_i(ctrl_oe), .flag_i(flag_o), .flag_oe_i(flag_oe),
		.clear_n_i(clear_n), .addr_pin_o(addr_pin), .ras_pin_o(ras_pin), .flag_pin_o(flag_pin));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [8:0] seen(input int kind);
		case (kind)
			0: seen = addr_o;
			1: seen = {5'h00, ras_o};
			2: seen = {8'h00, cas_o};
			3: seen = {8'h00, we_o};
			4: seen = {7'h00, flag_o, flag_oe};
			5: seen = {8'h00, addr_oe};
			6: seen = {8'h00, ctrl_oe};
			8: seen = gap_ok;
			default: seen = {5'h00, ras_pin};
		endcase
	endfunction

	task automatic check(input logic [8:0] got, input logic [8:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask

	task automatic note(input int kind, input logic [8:0] exp);
		notes.push_back('{kind, exp});
	endtask

	task automatic refresh_pulse(input logic [8:0] cnt, input logic [8:0] eoc);
		ras_in_n <= 1'b0;
		step(5);
		note(0, cnt);
		note(1, 9'h000);
		note(2, 9'h001);
		note(4, {8'h00, cnt == eoc});
		ras_in_n <= 1'b1;
		step(5);
	endtask

	// Compares the oldest notes once the outputs have settled
	initial begin : monitor
		note_type n;
		forever begin
			@(negedge ref_clk_i);
			while (notes.size() > 0) begin
				n = notes.pop_front();
				check(seen(n.kind), n.exp);
			end
		end
	end

	initial begin : watchdog
		step(30000);
		errors++;
		stop_test();
	end

	initial begin : main
		logic [8:0] r0;
		logic [8:0] c0;
		int n;
		step(6);
		reset_n_i <= 1'b1;
		step(1);
		note(5, 9'h000);
		note(6, 9'h001);
		note(1, 9'h00F);
		step(8);
		for (int b = 0; b < 4; b++) begin
			r0 = 9'(rnd());
			c0 = 9'(rnd());
			row_addr <= r0;
			col_addr <= c0;
			bank_select <= 2'(b);
			latch <= 1'b1;
			step(5);
			note(0, r0);
			note(1, 9'h00F);
			latch <= 1'b0;
			step(1);
			row_addr <= 9'(rnd());
			col_addr <= 9'(rnd());
			bank_select <= 2'(b + 1);
			step(5);
			note(0, r0);
			ras_in_n <= 1'b0;
			step(5);
			note(1, {5'h00, ~(4'h1 << b)});
			row_col <= 1'b0;
			step(5);
			note(0, c0);
			note(2, 9'h001);
			cas_in_n <= 1'b0;
			step(5);
			note(2, 9'h000);
			win_n <= 1'b0;
			step(5);
			note(3, 9'h000);
			{ras_in_n, row_col, cas_in_n, win_n} <= 4'hF;
			step(5);
			note(3, 9'h001);
			note(1, 9'h00F);
		end
		$display("Test access done");
		select_n <= 1'b1;
		step(6);
		note(5, 9'h000);
		note(6, 9'h000);
		note(7, 9'h00F);
		select_n <= 1'b0;
		n = 0;
		while (addr_oe !== 1'b1 && n < 40) begin
			@(negedge ref_clk_i);
			n++;
		end
		gap_ok = {8'h00, n >= 10 && n <= 16};
		step(1);
		note(8, 9'h001);
		$display("Test deselect done");
		mode <= MODE_EXT_REFRESH;
		for (int i = 0; i < 3; i++) begin
			if (i > 0) begin
				bank_select <= 2'(i);
				latch <= 1'b1;
				mode <= MODE_SET_EOC;
				step(6);
				mode <= MODE_EXT_REFRESH;
				step(6);
				clear_n <= 1'b0;
				step(6);
				clear_n <= 1'b1;
				step(6);
			end
			for (int c = 0; c <= int'(eocs[i]) + (i == 2); c++) refresh_pulse(9'(c), eocs[i]);
			$display("Test refresh end-of-count %0d done", eocs[i]);
		end
		foreach (amodes[k]) begin
			mode <= amodes[k];
			step(5);
			{ras_in_n, row_col} <= 2'h0;
			step(5);
			note(2, {8'h00, amodes[k] == MODE_ALL_BANK});
			note(1, (amodes[k] == MODE_ALL_BANK) ? 9'h000 : 9'h00B);
			cas_in_n <= 1'b0;
			step(5);
			note(2, 9'h000);
			{ras_in_n, row_col, cas_in_n} <= 3'h7;
			step(5);
			note(2, 9'h001);
		end
		$display("Test auto access done");
		mode <= MODE_AUTO_REFRESH;
		step(5);
		ras_in_n <= 1'b0;
		step(5);
		note(4, 9'h000);
		{ras_in_n, row_col} <= 2'h2;
		step(5);
		note(4, 9'h000);
		row_col <= 1'b1;
		step(5);
		row_col <= 1'b0;
		step(5);
		note(4, 9'h001);
		row_col <= 1'b1;
		mode <= MODE_BURST_REFRESH;
		clear_n <= 1'b0;
		step(5);
		clear_n <= 1'b1;
		step(5);
		note(0, 9'h000);
		note(2, 9'h001);
		note(4, 9'h000);
		$display("Test refresh modes done");
		step(3);
		stop_test();
	end
endmodule // dram_address_strobe_driver_tb
